/* File: pcp_defines.svh */
// Constants of the power controller port: codes, field positions and timing.
`ifndef PCP_DEFINES_SVH
`define PCP_DEFINES_SVH
// ----------------------------------------------------------------------------
// Local monitor message layout
// ----------------------------------------------------------------------------
`define PCP_MON_HDR 8'h80
`define PCP_OP_MSB 7
`define PCP_OP_LSB 5
`define PCP_DATA_MSB 4
`define PCP_DATA_LSB 2
`define PCP_ADDR_MSB 1
`define PCP_ADDR_LSB 0
`define PCP_OP_WRITE 3'h3
`define PCP_OP_READ 3'h2
`define PCP_FEED_REQ_BYTE 8'hf0
`define PCP_ANS_PAD 5'h00
// ----------------------------------------------------------------------------
// C/I codes
// ----------------------------------------------------------------------------
`define PCP_CI_INT 4'h6
`define PCP_CI_POWER_OFF 4'h3
`define PCP_CI_LTD 4'h3
`define PCP_CI_SOFT_RST 4'h1
`define PCP_INT_FRAMES 3'h4
// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PCP_CLK_NS 20
`define PCP_STROBE_NS 100
`define PCP_STROBE_CYC ((`PCP_STROBE_NS + `PCP_CLK_NS - 1) / `PCP_CLK_NS)
`define PCP_FEED_BITS 4'h8
`define PCP_SYNC_W 6
`endif

/* File: pcp_pkg.sv */
// Types shared by the power controller port modules.
package pcp_pkg;
  typedef enum logic [1:0] {
    PCP_ACC_IDLE = 2'b00,
    PCP_ACC_SETUP = 2'b01,
    PCP_ACC_STROBE = 2'b10,
    PCP_ACC_HOLD = 2'b11
  } pcp_acc_state_t;
  typedef enum logic {
    PCP_MODE_NT = 1'b0,
    PCP_MODE_LT = 1'b1
  } pcp_mode_t;
endpackage

/* File: pcp_acc_if.sv */
// Carrier between the command decoder and the port access sequencer.
`timescale 1ns/1ps
interface pcp_acc_if;
  logic start;
  logic is_read;
  logic [1:0] addr;
  logic [2:0] wdata;
  logic busy;
  logic done;
  logic [2:0] rdata;
  logic [2:0] pin_data_in;
  logic [2:0] pin_data_out;
  logic [2:0] pin_data_oe_n;
  logic [1:0] pin_addr;
  logic pin_rd_n;
  logic pin_wr_n;
  modport ctrl (output start, is_read, addr, wdata, pin_data_in,
                input busy, done, rdata, pin_data_out, pin_data_oe_n, pin_addr, pin_rd_n, pin_wr_n);
  modport seq (input start, is_read, addr, wdata, pin_data_in,
               output busy, done, rdata, pin_data_out, pin_data_oe_n, pin_addr, pin_rd_n, pin_wr_n);
endinterface

/* File: pcp_port_seq.sv */
// Port access sequencer: address latch, data drive and read/write strobes.
`timescale 1ns/1ps
`include "pcp_defines.svh"
module pcp_port_seq #(
  parameter int STROBE_CYC = `PCP_STROBE_CYC
) (
  input wire logic sys_clk, // System clock
  input wire logic nrst, // Async reset, active low
  pcp_acc_if.seq acc // Access requests and pins
);
  import pcp_pkg::*;

  pcp_acc_state_t state, next_state;
  logic [3:0] cnt, next_cnt;
  logic [1:0] addr, next_addr;
  logic [2:0] dout, next_dout;
  logic [2:0] oe_n, next_oe_n;
  logic rd_n, next_rd_n;
  logic wr_n, next_wr_n;
  logic rd_op, next_rd_op;
  logic done, next_done;
  logic [2:0] rdata, next_rdata;

  // --------------------------------------------------------------------------
  // Access sequence
  // --------------------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_addr = addr;
    next_dout = dout;
    next_oe_n = oe_n;
    next_rd_n = 1'b1;
    next_wr_n = 1'b1;
    next_rd_op = rd_op;
    next_done = 1'b0;
    next_rdata = rdata;
    unique case (state)
      PCP_ACC_IDLE: begin
        if (acc.start) begin
          next_addr = acc.addr;
          next_rd_op = acc.is_read;
          next_dout = acc.wdata;
          next_oe_n = acc.is_read ? 3'h7 : 3'h0;
          next_state = PCP_ACC_SETUP;
        end
      end
      PCP_ACC_SETUP: begin
        next_cnt = 4'(STROBE_CYC - 1);
        next_rd_n = ~rd_op;
        next_wr_n = rd_op;
        next_state = PCP_ACC_STROBE;
      end
      PCP_ACC_STROBE: begin
        if (cnt == 4'h0) begin
          if (rd_op) begin
            next_rdata = acc.pin_data_in;
          end
          next_state = PCP_ACC_HOLD;
        end else begin
          next_cnt = cnt - 4'h1;
          next_rd_n = rd_n;
          next_wr_n = wr_n;
        end
      end
      PCP_ACC_HOLD: begin
        // Write data is not held after the access
        next_oe_n = 3'h7;
        next_done = 1'b1;
        next_state = PCP_ACC_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state <= PCP_ACC_IDLE;
      cnt <= 4'h0;
      addr <= 2'h0;
      dout <= 3'h0;
      oe_n <= 3'h7;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      rd_op <= 1'b0;
      done <= 1'b0;
      rdata <= 3'h0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      addr <= next_addr;
      dout <= next_dout;
      oe_n <= next_oe_n;
      rd_n <= next_rd_n;
      wr_n <= next_wr_n;
      rd_op <= next_rd_op;
      done <= next_done;
      rdata <= next_rdata;
    end
  end

  assign acc.busy = (state != PCP_ACC_IDLE);
  assign acc.done = done;
  assign acc.rdata = rdata;
  assign acc.pin_addr = addr;
  assign acc.pin_data_out = dout;
  assign acc.pin_data_oe_n = oe_n;
  assign acc.pin_rd_n = rd_n;
  assign acc.pin_wr_n = wr_n;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  sequence s_wr_start;
    state == PCP_ACC_IDLE && acc.start && !acc.is_read;
  endsequence
  sequence s_wr_pulse;
    ##2 (!wr_n && oe_n == 3'h0)[*5] ##1 wr_n;
  endsequence
  property p_wr_strobe;
    @(posedge sys_clk) disable iff (!nrst) s_wr_start |-> s_wr_pulse;
  endproperty
  a_wr_strobe: assert property (p_wr_strobe) else $error("write strobe shape wrong");
  property p_addr_static;
    @(posedge sys_clk) disable iff (!nrst) (state == PCP_ACC_IDLE && !acc.start) |=> $stable(addr);
  endproperty
  a_addr_static: assert property (p_addr_static) else $error("address moved between accesses");
  property p_rd_no_drive;
    @(posedge sys_clk) disable iff (!nrst) !rd_n |-> (oe_n == 3'h7);
  endproperty
  a_rd_no_drive: assert property (p_rd_no_drive) else $error("data driven during read");
endmodule

/* File: pcp_top.sv */
// Power controller port: peripheral port, interrupt reporting, supply pins.
//
// Summary of operation
// - Three data, two address, strobes, interrupt input
// - Address outputs stay latched between accesses
// - Port accessed only by local monitor commands
// - Any interrupt edge sends code 0110, four frames, except while LT primary high sends 0011
// - Write latches address, drives unlatched data
// - Read latches address, samples data, answers
// - Port and interrupt same in LT, NT
// - NT: supply status inputs copied upstream
// - NT auto: close-loop command sets supply disable
// - NT: return-normal or reset clears disable
// - LT: primary high sends 0011, test, drops link
// - LT: feed value captured, reported on request
// - LT: line-disable C/I 0011 sets supply disable
// - Soft reset leaves supply disable unchanged
// - LT: disable high keeps test state
// - Maintenance via IOM in LT, overhead in NT
// - Feed answer sent in next IOM frame
// - Primary sets M42, secondary sets M43, level
`timescale 1ns/1ps
`include "pcp_defines.svh"
module pcp_top (
  input wire logic sys_clk, // 50 MHz system clock
  input wire logic nrst, // Async reset, active low
  input wire pcp_pkg::pcp_mode_t mode, // LT or NT operation
  input wire logic auto_mode, // NT auto-mode select
  input wire logic frame_sync, // IOM frame start pulse
  input wire logic b1_bit_en, // B1 bit sample pulse
  input wire logic mon_valid, // Local monitor message strobe
  input wire logic [7:0] mon_hdr, // Message first byte
  input wire logic [7:0] mon_data, // Message second byte
  input wire logic ci_rx_valid, // Received C/I code strobe
  input wire logic [3:0] ci_rx_code, // Received C/I code
  input wire logic [3:0] ci_tx_default, // C/I code from the core
  input wire logic eoc_close_loop, // close_full_loop_command seen
  input wire logic eoc_return_normal, // return_normal_command seen
  input wire logic [2:0] port_data_in, // port_data_bits pin levels
  input wire logic port_int_in, // Peripheral interrupt pin
  input wire logic primary_supply_status, // Primary status pin
  input wire logic secondary_supply_status, // Secondary status / feed serial pin
  output logic [2:0] port_data_out, // port_data_bits drive value
  output logic [2:0] port_data_oe_n, // Data drive enable, active low
  output logic [1:0] port_addr_bits, // Latched address
  output logic port_read_strobe_n, // Read strobe, active low
  output logic port_write_strobe_n, // Write strobe, active low
  output logic ans_valid, // Answer message strobe
  output logic [7:0] ans_data, // Answer second byte
  output logic [3:0] ci_tx_code, // C/I code to send
  output logic supply_disable_output, // Supply disable pin
  output logic force_test_state, // Hold core in test, drop link
  output logic soft_reset_req, // Soft reset pulse to the core
  output logic oh_m42, // Upstream overhead M42
  output logic oh_m43 // Upstream overhead M43
);
  import pcp_pkg::*;

  pcp_acc_if acc ();

  pcp_port_seq u_seq (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .acc(acc)
  );

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  // Bits: 0-2 data, 3 interrupt, 4 primary, 5 secondary
  logic [`PCP_SYNC_W-1:0] pin_raw, s1, s2, s3, stable, next_stable;
  assign pin_raw = {secondary_supply_status, primary_supply_status, port_int_in, port_data_in};

  genvar gi;
  generate
    for (gi = 0; gi < `PCP_SYNC_W; gi++) begin : g_sync
      // A change counts only once two later stages agree
      always_comb begin
        next_stable[gi] = (s2[gi] == s3[gi]) ? s3[gi] : stable[gi];
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      stable <= '0;
    end else begin
      s1 <= pin_raw;
      s2 <= s1;
      s3 <= s2;
      stable <= next_stable;
    end
  end

  logic is_lt;
  logic int_edge;
  assign is_lt = (mode == PCP_MODE_LT);
  assign int_edge = (next_stable[3] != stable[3]);
  assign acc.pin_data_in = stable[2:0];

  // --------------------------------------------------------------------------
  // Command decode and answers
  // --------------------------------------------------------------------------
  logic mon_ok, wr_cmd, rd_cmd, feed_cmd;
  logic rd_wait, next_rd_wait;
  logic ans_pend, next_ans_pend;
  logic [7:0] ans_buf, next_ans_buf;
  logic next_ans_valid;
  logic [7:0] next_ans_data;
  logic [7:0] feed_val, next_feed_val;
  logic [7:0] feed_sh, next_feed_sh;
  logic [3:0] feed_cnt, next_feed_cnt;

  // One command in flight; others are ignored until its access ends or its answer leaves
  assign mon_ok = mon_valid && (mon_hdr == `PCP_MON_HDR) && !acc.busy && !rd_wait && !ans_pend;
  assign wr_cmd = mon_ok && (mon_data[`PCP_OP_MSB:`PCP_OP_LSB] == `PCP_OP_WRITE);
  assign rd_cmd = mon_ok && (mon_data[`PCP_OP_MSB:`PCP_OP_LSB] == `PCP_OP_READ);
  assign feed_cmd = mon_ok && is_lt && (mon_data == `PCP_FEED_REQ_BYTE);

  assign acc.start = wr_cmd || rd_cmd;
  assign acc.is_read = rd_cmd;
  assign acc.addr = mon_data[`PCP_ADDR_MSB:`PCP_ADDR_LSB];
  assign acc.wdata = mon_data[`PCP_DATA_MSB:`PCP_DATA_LSB];

  always_comb begin
    next_rd_wait = rd_wait;
    next_ans_pend = ans_pend;
    next_ans_buf = ans_buf;
    next_ans_valid = 1'b0;
    next_ans_data = ans_data;
    if (rd_cmd) begin
      next_rd_wait = 1'b1;
    end
    if (rd_wait && acc.done) begin
      next_rd_wait = 1'b0;
      next_ans_pend = 1'b1;
      next_ans_buf = {acc.rdata, `PCP_ANS_PAD};
    end
    if (feed_cmd) begin
      next_ans_pend = 1'b1;
      next_ans_buf = feed_val;
    end
    if (ans_pend && frame_sync) begin
      next_ans_pend = 1'b0;
      next_ans_valid = 1'b1;
      next_ans_data = ans_buf;
    end
  end

  // Feed value arrives MSB first in the B1 slot; frame start realigns
  always_comb begin
    next_feed_sh = feed_sh;
    next_feed_cnt = feed_cnt;
    next_feed_val = feed_val;
    if (frame_sync) begin
      next_feed_cnt = 4'h0;
    end else if (is_lt && b1_bit_en && feed_cnt != `PCP_FEED_BITS) begin
      next_feed_sh = {feed_sh[6:0], stable[5]};
      next_feed_cnt = feed_cnt + 4'h1;
      if (feed_cnt == `PCP_FEED_BITS - 4'h1) begin
        next_feed_val = {feed_sh[6:0], stable[5]};
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rd_wait <= 1'b0;
      ans_pend <= 1'b0;
      ans_buf <= 8'h00;
      ans_valid <= 1'b0;
      ans_data <= 8'h00;
      feed_sh <= 8'h00;
      feed_cnt <= 4'h0;
      feed_val <= 8'h00;
    end else begin
      rd_wait <= next_rd_wait;
      ans_pend <= next_ans_pend;
      ans_buf <= next_ans_buf;
      ans_valid <= next_ans_valid;
      ans_data <= next_ans_data;
      feed_sh <= next_feed_sh;
      feed_cnt <= next_feed_cnt;
      feed_val <= next_feed_val;
    end
  end

  // --------------------------------------------------------------------------
  // C/I reporting and maintenance pins
  // --------------------------------------------------------------------------
  logic [2:0] int_cnt, next_int_cnt;
  logic [3:0] next_ci;
  logic next_dis, next_test, next_soft, next_m42, next_m43;
  logic ltd_rx, soft_rx, power_off;
  assign ltd_rx = ci_rx_valid && (ci_rx_code == `PCP_CI_LTD);
  assign soft_rx = ci_rx_valid && (ci_rx_code == `PCP_CI_SOFT_RST);
  assign power_off = is_lt && stable[4];

  always_comb begin
    next_int_cnt = int_cnt;
    if (frame_sync && int_cnt != 3'h0) begin
      next_int_cnt = int_cnt - 3'h1;
    end
    // A new edge restarts the count, even in a frame boundary cycle
    if (int_edge) begin
      next_int_cnt = `PCP_INT_FRAMES;
    end
    if (power_off) begin
      next_ci = `PCP_CI_POWER_OFF;
    end else if (next_int_cnt != 3'h0) begin
      next_ci = `PCP_CI_INT;
    end else begin
      next_ci = ci_tx_default;
    end
    next_dis = supply_disable_output;
    if (is_lt) begin
      if (ltd_rx) begin
        next_dis = 1'b1;
      end
    end else begin
      if (eoc_return_normal) begin
        next_dis = 1'b0;
      end
      if (auto_mode && eoc_close_loop) begin
        next_dis = 1'b1;
      end
    end
    // Soft reset goes to the core only; the disable pin is untouched
    next_soft = soft_rx;
    next_test = is_lt && (power_off || next_dis);
    next_m42 = !is_lt && stable[4];
    next_m43 = !is_lt && stable[5];
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      int_cnt <= 3'h0;
      ci_tx_code <= 4'h0;
      supply_disable_output <= 1'b0;
      force_test_state <= 1'b0;
      soft_reset_req <= 1'b0;
      oh_m42 <= 1'b0;
      oh_m43 <= 1'b0;
    end else begin
      int_cnt <= next_int_cnt;
      ci_tx_code <= next_ci;
      supply_disable_output <= next_dis;
      force_test_state <= next_test;
      soft_reset_req <= next_soft;
      oh_m42 <= next_m42;
      oh_m43 <= next_m43;
    end
  end

  // Port pins straight from sequencer flops
  assign port_data_out = acc.pin_data_out;
  assign port_data_oe_n = acc.pin_data_oe_n;
  assign port_addr_bits = acc.pin_addr;
  assign port_read_strobe_n = acc.pin_rd_n;
  assign port_write_strobe_n = acc.pin_wr_n;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence s_int_hit;
    int_edge && !power_off;
  endsequence
  property p_int_code;
    s_int_hit |=> (ci_tx_code == `PCP_CI_INT) && (int_cnt == 3'h4);
  endproperty
  a_int_code: assert property (p_int_code) else $error("interrupt code not sent");
  property p_int_end;
    (int_cnt == 3'h1 && frame_sync && !int_edge && !power_off) |=> (ci_tx_code == $past(ci_tx_default));
  endproperty
  a_int_end: assert property (p_int_end) else $error("interrupt code overran");
  property p_off_code;
    power_off |=> (ci_tx_code == `PCP_CI_POWER_OFF) && force_test_state;
  endproperty
  a_off_code: assert property (p_off_code) else $error("power off not reported");
  property p_ltd_set;
    (is_lt && ltd_rx) |=> supply_disable_output ##1 force_test_state;
  endproperty
  a_ltd_set: assert property (p_ltd_set) else $error("line disable ignored");
  property p_soft_keep;
    (soft_rx && !eoc_return_normal && !eoc_close_loop) |=> $stable(supply_disable_output) && soft_reset_req;
  endproperty
  a_soft_keep: assert property (p_soft_keep) else $error("soft reset moved disable");
  property p_nt_set;
    (!is_lt && auto_mode && eoc_close_loop) |=> supply_disable_output;
  endproperty
  a_nt_set: assert property (p_nt_set) else $error("close loop did not disable");
  property p_nt_clr;
    (!is_lt && eoc_return_normal && !(auto_mode && eoc_close_loop)) |=> !supply_disable_output;
  endproperty
  a_nt_clr: assert property (p_nt_clr) else $error("return normal did not clear");
  property p_nt_hold;
    (!is_lt && !auto_mode && !eoc_return_normal) |=> $stable(supply_disable_output);
  endproperty
  a_nt_hold: assert property (p_nt_hold) else $error("disable set outside auto mode");
  property p_overhead;
    (!is_lt && $past(!is_lt)) |-> (oh_m42 == $past(stable[4])) && (oh_m43 == $past(stable[5]));
  endproperty
  a_overhead: assert property (p_overhead) else $error("overhead bits wrong");
  property p_test_hold;
    (is_lt && supply_disable_output) |=> force_test_state;
  endproperty
  a_test_hold: assert property (p_test_hold) else $error("left test while disabled");
  property p_ans_frame;
    (ans_pend && frame_sync) |=> ans_valid && (ans_data == $past(ans_buf));
  endproperty
  a_ans_frame: assert property (p_ans_frame) else $error("answer missed frame");
  property p_feed_ans;
    feed_cmd |=> ans_pend && (ans_buf == $past(feed_val));
  endproperty
  a_feed_ans: assert property (p_feed_ans) else $error("feed value not queued");
endmodule

/* File: pcp_periph.sv */
// Model of the peripheral circuit on the far side of the power controller port.
`timescale 1ns/1ps
module pcp_periph (
  input wire logic sys_clk, // System clock
  input wire logic lt_mode, // Secondary pin carries feed serial
  input wire logic [2:0] data_out, // Device drive value
  input wire logic [2:0] data_oe_n, // Device drive enable, active low
  input wire logic [1:0] addr, // Latched address
  input wire logic rd_n, // Read strobe, active low
  input wire logic wr_n, // Write strobe, active low
  input wire logic frame_sync, // Frame start pulse
  input wire logic b1_bit_en, // B1 bit pulse
  input wire logic [7:0] feed_val, // Feed value to send
  input wire logic sec_lvl, // Secondary supply level
  output logic [2:0] data_in, // Resolved data lines
  output logic sec_pin // Secondary status pin
);
  logic [2:0] regs [4] = '{default: 3'h0};
  logic [2:0] last = 3'h0;
  logic [7:0] shift = 8'h00;
  // --------------------------------------------------------------------------
  // Data lines
  // --------------------------------------------------------------------------
  // Undriven lines toggle, so stale data never reads as valid
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (!data_oe_n[i])
        data_in[i] = data_out[i];
      else if (!rd_n)
        data_in[i] = regs[addr][i];
      else
        data_in[i] = ~last[i];
    end
  end
  always_ff @(posedge sys_clk) begin
    last <= data_in;
    if (!wr_n)
      regs[addr] <= data_in;
    if (frame_sync)
      shift <= feed_val;
    else if (b1_bit_en)
      shift <= {shift[6:0], 1'h0};
  end
  assign sec_pin = lt_mode ? shift[7] : sec_lvl;
endmodule

/* File: tb_pcp_top.sv */
// Self-checking bench for the power controller port.
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, got, exp); end end
module tb_pcp_top;
  import pcp_pkg::*;
  logic sys_clk = 0, nrst = 0, auto_mode = 0, frame_sync = 0, b1_bit_en = 0;
  logic mon_valid = 0, ci_rx_valid = 0, eoc_close_loop = 0, eoc_return_normal = 0;
  logic port_int_in = 0, prim = 0, sec_lvl = 0, sec_pin, srr;
  logic [7:0] mon_hdr = 8'h00, mon_data = 8'h00, feed_val = 8'h00, ans_data, exp_v;
  logic [3:0] ci_rx_code = 4'h0, ci_tx_code;
  logic [2:0] port_data_in, port_data_out, port_data_oe_n;
  logic [2:0] wd [4];
  logic [1:0] port_addr_bits;
  logic [5:0] fcnt = 6'h00;
  logic [31:0] rnd;
  logic port_read_strobe_n, port_write_strobe_n, ans_valid, supply_disable_output;
  logic force_test_state, soft_reset_req, oh_m42, oh_m43;
  pcp_mode_t mode = PCP_MODE_LT;
  logic [7:0] exp_q [$];
  int fail_count = 0, checks = 0;
  pcp_top pcp_top_i (.sys_clk, .nrst, .mode, .auto_mode, .frame_sync, .b1_bit_en, .mon_valid, .mon_hdr,
    .mon_data, .ci_rx_valid, .ci_rx_code, .ci_tx_default(4'hc), .eoc_close_loop, .eoc_return_normal,
    .port_data_in, .port_int_in, .primary_supply_status(prim), .secondary_supply_status(sec_pin),
    .port_data_out, .port_data_oe_n, .port_addr_bits, .port_read_strobe_n, .port_write_strobe_n, .ans_valid,
    .ans_data, .ci_tx_code, .supply_disable_output, .force_test_state, .soft_reset_req, .oh_m42, .oh_m43);
  pcp_periph pcp_periph_i (.sys_clk, .lt_mode(mode == PCP_MODE_LT), .data_out(port_data_out),
    .data_oe_n(port_data_oe_n), .addr(port_addr_bits), .rd_n(port_read_strobe_n), .wr_n(port_write_strobe_n),
    .frame_sync, .b1_bit_en, .feed_val, .sec_lvl, .data_in(port_data_in), .sec_pin);
  // --------------------------------------------------------------------------
  // Clock, frame timing, answer watcher
  // --------------------------------------------------------------------------
  initial forever #10 sys_clk = ~sys_clk;
  // Eight B1 pulses, six cycles apart, leave the synchroniser time to settle
  always @(posedge sys_clk) begin
    fcnt <= fcnt + 6'h01;
    frame_sync <= (fcnt == 6'h3f);
    b1_bit_en <= (fcnt % 6 == 5) && (fcnt < 48);
  end
  always @(posedge sys_clk) begin
    if (ans_valid === 1'h1) begin
      if (exp_q.size() == 0) begin
        fail_count++;
        $display("[FAIL] %0t unexpected answer", $time);
      end else begin
        exp_v = exp_q.pop_front();
        `CHK(ans_data, exp_v)
      end
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic end_of_test();
    if (fail_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic timeout();
    fail_count++;
    $display("[FAIL] %0t wait ran out", $time);
    end_of_test();
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic mon_cmd(input logic [7:0] h, input logic [7:0] d);
    @(posedge sys_clk);
    mon_valid <= 1;
    mon_hdr <= h;
    mon_data <= d;
    @(posedge sys_clk);
    mon_valid <= 0;
  endtask
  task automatic drain();
    for (int i = 0; i < 80 && exp_q.size() > 0; i++)
      wait_cyc(1);
    if (exp_q.size() > 0)
      timeout();
  endtask
  task automatic ci_cmd(input logic [3:0] c);
    @(posedge sys_clk);
    ci_rx_valid <= 1;
    ci_rx_code <= c;
    @(posedge sys_clk);
    ci_rx_valid <= 0;
    srr = 0;
    repeat (3) begin
      #1;
      srr |= soft_reset_req;
      @(posedge sys_clk);
    end
    #1;
    `CHK(srr, c == 4'h1)
  endtask
  task automatic pulse_eoc(input logic c);
    @(posedge sys_clk);
    eoc_close_loop <= c;
    eoc_return_normal <= !c;
    @(posedge sys_clk);
    eoc_close_loop <= 0;
    eoc_return_normal <= 0;
    wait_cyc(2);
  endtask
  task automatic int_check();
    int n;
    n = 0;
    for (int i = 0; i < 100 && frame_sync !== 1'h1; i++)
      wait_cyc(1);
    if (frame_sync !== 1'h1)
      timeout();
    @(posedge sys_clk);
    port_int_in <= ~port_int_in;
    for (int i = 0; i < 12 && ci_tx_code !== 4'h6; i++)
      wait_cyc(1);
    `CHK(ci_tx_code, 4'h6)
    for (int i = 0; i < 300 && n < 4; i++) begin
      wait_cyc(1);
      if (frame_sync === 1'h1)
        n++;
    end
    if (n < 4)
      timeout();
    `CHK(ci_tx_code, 4'h6)
    wait_cyc(3);
    `CHK(ci_tx_code, 4'hc)
  endtask
  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    rnd = 32'h83cc;
    repeat (4) @(posedge sys_clk);
    nrst <= 1;
    wait_cyc(1);
    `CHK(supply_disable_output, 1'h0)
    `CHK(port_data_oe_n, 3'h7)
    for (int m = 0; m < 2; m++) begin
      @(posedge sys_clk);
      mode <= m ? PCP_MODE_NT : PCP_MODE_LT;
      for (int a = 0; a < 4; a++) begin
        rnd = lfsr(rnd);
        wd[a] = rnd[2:0];
        mon_cmd(8'h80, {3'h3, rnd[2:0], a[1:0]});
        wait_cyc(10);
        `CHK(port_addr_bits, a[1:0])
      end
      mon_cmd(8'h81, 8'h61);
      wait_cyc(10);
      `CHK(port_addr_bits, 2'h3)
      for (int a = 0; a < 4; a++) begin
        exp_q.push_back({wd[a], 5'h00});
        mon_cmd(8'h80, {3'h2, 3'h0, a[1:0]});
        drain();
        `CHK(port_addr_bits, a[1:0])
      end
      for (int e = 0; e < 2; e++)
        int_check();
    end
    @(posedge sys_clk);
    mode <= PCP_MODE_LT;
    for (int k = 0; k < 3; k++) begin
      rnd = lfsr(rnd);
      @(posedge sys_clk);
      feed_val <= rnd[7:0];
      wait_cyc(140);
      exp_q.push_back(rnd[7:0]);
      mon_cmd(8'h80, 8'hf0);
      drain();
    end
    @(posedge sys_clk);
    prim <= 1;
    wait_cyc(6);
    `CHK(ci_tx_code, 4'h3)
    `CHK(force_test_state, 1'h1)
    @(posedge sys_clk);
    prim <= 0;
    wait_cyc(6);
    `CHK(force_test_state, 1'h0)
    ci_cmd(4'h3);
    `CHK(supply_disable_output, 1'h1)
    `CHK(force_test_state, 1'h1)
    ci_cmd(4'h1);
    `CHK(supply_disable_output, 1'h1)
    @(posedge sys_clk);
    mode <= PCP_MODE_NT;
    nrst <= 0;
    wait_cyc(2);
    `CHK(supply_disable_output, 1'h0)
    @(posedge sys_clk);
    nrst <= 1;
    for (int s = 0; s < 4; s++) begin
      @(posedge sys_clk);
      prim <= s[0];
      sec_lvl <= s[1];
      wait_cyc(6);
      `CHK(oh_m42, s[0])
      `CHK(oh_m43, s[1])
    end
    for (int am = 0; am < 2; am++) begin
      @(posedge sys_clk);
      auto_mode <= am[0];
      pulse_eoc(1);
      `CHK(supply_disable_output, am[0])
      pulse_eoc(0);
      `CHK(supply_disable_output, 1'h0)
    end
    end_of_test();
  end
endmodule
